/* File: core/fdc_map.vh */
/*
 Constants for the disc controller core: register select codes, status
 bit positions, command encodings, timing figures and derived counts.
 Assumes a 10 MHz reference clock; included by bare name.
*/
`ifndef FDC_MAP_VH
`define FDC_MAP_VH

// Register select codes
`define FDC_SEL_CMD_STAT 2'h0
`define FDC_SEL_TRACK 2'h1
`define FDC_SEL_SECTOR 2'h2
`define FDC_SEL_DATA 2'h3

// Status bit positions
`define FDC_ST_BUSY 0
`define FDC_ST_DRQ 1
`define FDC_ST_TRK0 2
`define FDC_ST_LOST 2
`define FDC_ST_WPROT 6
`define FDC_ST_NRDY 7

// Command families, upper nibble of the command byte
`define FDC_CMD_RESTORE 4'h0
`define FDC_CMD_SEEK 4'h1
`define FDC_CMD_STEP_IN 4'h5
`define FDC_CMD_STEP_OUT 4'h7
`define FDC_CMD_READ 4'h8
`define FDC_CMD_WRITE 4'ha
`define FDC_CMD_FORCE 4'hd

// Tracks from this one up to the next carry the high-track indication
`define FDC_HIGH_TRACK_LO 8'h2c
`define FDC_HIGH_TRACK_HI 8'h4c

// Timing, in ns, and cycle counts at 10 MHz (100 ns)
`define FDC_CLK_NS 100
`define FDC_WP_MFM_NS 250
`define FDC_WP_FM_NS 500
`define FDC_WP_MFM_CYC ((`FDC_WP_MFM_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_WP_FM_CYC ((`FDC_WP_FM_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_PRECOMP_CYC 1
`define FDC_STEP_PULSE_CYC 40
`define FDC_BIT_CELL_CYC 40

// Sector payload length
`define FDC_SECTOR_BYTES 128

`endif

/* File: core/fdc_fifo.v */
/*
 Synchronous FIFO with parameterised width and depth, valid/ready on
 both sides. Assumes one clock, an active-low async reset and a common
 clock enable that freezes it.
*/
`timescale 1ns/1ps
module fdc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_flush,
  // Fill side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // Drain side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Honest flags straight from the occupancy count
  assign o_in_ready = (count_reg != DEPTH[AW:0]);
  assign o_out_valid = (count_reg != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr_reg];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Storage array has no reset, saves area
  always @(posedge i_clk) begin
    if (i_ce && push && !i_flush) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers and count
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (i_ce) begin
      if (i_flush) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
            {AW{1'b0}} : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
            {AW{1'b0}} : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
          count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end
endmodule // fdc_fifo

/* File: core/fdc_core.v */
/*
 Floppy disc controller core: host register port, command sequencer,
 head stepping, write-data pulse generation and read byte assembly.
 Assumes all pins synchronous to i_ref_clk; the analogue separator is
 outside, raw read arrives as already separated bits with a strobe.
*/
`timescale 1ns/1ps
`include "fdc_map.vh"

// Notes on behaviour
// - Precomp input high delays double-density write pulses by a precompensation shift.
// - Master reset low holds reset; on release a Restore runs.
// - Write strobe and chip select low store the bus byte.
// - Read strobe and chip select low drive the register; else released.
// - Two select lines with strobes choose the register accessed.
// - Data request when read byte assembled or write data register empty.
// - Interrupt on command end; cleared by status read or command write.
// - One step output pulse per head step.
// - Direction high steps inward, low outward, steady for each pulse.
// - Clock halved when mini-floppy enable and size select both low.
// - High-track flag on tracks 44 to 76 during read or write.
// - Write gate raised before any data is written.
// - One write pulse per flux change, 250ns MFM or 500ns FM; the core gives 3 cycles (300ns) for MFM.
// - Drive ready sampled before read/write; low skips and interrupts.
// - Head positioning commands ignore drive ready.
// - Write command samples protect; low ends it and sets status bit.
// - Density select low means double density, high single density.
// - Head engaged input high means head treated as loaded.
// - Head load output requests head against medium.
// - Double density engages write precompensation only with the precomp input high.
module fdc_core #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5,
  parameter SECTOR_BYTES = `FDC_SECTOR_BYTES
) (
  // Clock, reset, enable
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_master_reset_n,
  // Host port
  input wire i_chip_select_n,
  input wire i_host_write_strobe_n,
  input wire i_host_read_strobe_n,
  input wire [1:0] i_register_select,
  input wire [7:0] i_bus_in,
  output reg [7:0] o_bus_out,
  output reg o_bus_oe,
  output reg o_data_request,
  output reg o_command_done_irq,
  // Configuration pins
  input wire i_precomp_enable_in,
  input wire i_mini_floppy_enable_n,
  input wire i_size_select_n,
  input wire i_density_select_n,
  // Drive inputs
  input wire i_drive_ready,
  input wire i_write_protect_n,
  input wire i_track_zero_n,
  input wire i_index_pulse_n,
  input wire i_head_engaged_in,
  input wire i_raw_read_bit,
  input wire i_raw_read_strobe,
  // Drive outputs
  output reg o_step,
  output reg o_step_direction,
  output reg o_head_load_out,
  output reg o_write_gate,
  output reg o_write_pulse_out,
  output reg o_high_track_flag
);
  // Sequencer states, one-hot
  localparam ST_IDLE = 8'h01;
  localparam ST_STEP = 8'h02;
  localparam ST_SETTLE = 8'h04;
  localparam ST_HEAD = 8'h08;
  localparam ST_READ = 8'h10;
  localparam ST_WGATE = 8'h20;
  localparam ST_WRITE = 8'h40;
  localparam ST_DONE = 8'h80;
  localparam integer WP_MFM_CYC = `FDC_WP_MFM_CYC;
  localparam integer WP_FM_CYC = `FDC_WP_FM_CYC;

  reg [7:0] state_reg;
  reg [7:0] command_reg;
  reg [7:0] status_reg;
  reg [7:0] track_reg;
  reg [7:0] sector_reg;
  reg [7:0] data_reg;
  reg [7:0] target_reg;
  reg [5:0] timer_reg;
  reg [7:0] bytes_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [2:0] pulse_cnt_reg;
  reg precomp_reg;
  reg restore_pend_reg;
  reg mr_prev_reg;
  reg half_reg;
  reg wr_prev_reg;
  reg rd_prev_reg;

  wire tick;
  wire double_density;
  wire precomp_on;
  wire wr_edge;
  wire rd_edge;
  wire [3:0] cmd_family;
  wire is_type1;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_push;
  wire fifo_pop;
  wire fifo_flush;
  wire ce;

  // Internal halving when both straps low
  assign tick = (i_mini_floppy_enable_n | i_size_select_n) | half_reg;
  assign ce = i_ce & i_master_reset_n;
  assign double_density = ~i_density_select_n;
  // Precomp needs the pin and double density
  assign precomp_on = i_precomp_enable_in & double_density;
  assign wr_edge = ~i_chip_select_n & ~i_host_write_strobe_n & wr_prev_reg;
  assign rd_edge = ~i_chip_select_n & ~i_host_read_strobe_n & rd_prev_reg;
  assign cmd_family = command_reg[7:4];
  assign is_type1 = ~command_reg[7];

  // Data buffer: host bytes in write mode, disc bytes in read mode
  assign fifo_push =
    (state_reg[4] ? (i_raw_read_strobe && bit_cnt_reg == 4'h7 && tick) :
    (wr_edge && i_register_select == `FDC_SEL_DATA));
  assign fifo_pop = state_reg[6] ? (tick && bit_cnt_reg == 4'h0 &&
    timer_reg == 6'h00) : (rd_edge && i_register_select == `FDC_SEL_DATA);
  assign fifo_flush = wr_edge && i_register_select == `FDC_SEL_CMD_STAT;

  fdc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(ce),
    .i_flush(fifo_flush),
    .i_in_valid(fifo_push),
    .i_in_data(state_reg[4] ? {shift_reg[6:0], i_raw_read_bit} :
      i_bus_in),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_pop)
  );

  // Strobe history, edge detect on falling strobes
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
      half_reg <= 1'b0;
      mr_prev_reg <= 1'b0;
    end else if (i_ce) begin
      wr_prev_reg <= i_chip_select_n | i_host_write_strobe_n;
      rd_prev_reg <= i_chip_select_n | i_host_read_strobe_n;
      half_reg <= ~half_reg;
      mr_prev_reg <= i_master_reset_n;
    end
  end

  // Host read path, registered drive
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_out <= 8'h00;
      o_bus_oe <= 1'b0;
    end else if (i_ce) begin
      o_bus_oe <= ~i_chip_select_n & ~i_host_read_strobe_n;
      case (i_register_select)
        `FDC_SEL_CMD_STAT: o_bus_out <= status_reg;
        `FDC_SEL_TRACK: o_bus_out <= track_reg;
        `FDC_SEL_SECTOR: o_bus_out <= sector_reg;
        default: o_bus_out <= fifo_out_valid ? fifo_out_data : data_reg;
      endcase
    end
  end

  // Command sequencer, registers and drive outputs
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      command_reg <= 8'h00;
      status_reg <= 8'h00;
      track_reg <= 8'h00;
      sector_reg <= 8'h01;
      data_reg <= 8'h00;
      target_reg <= 8'h00;
      timer_reg <= 6'h00;
      bytes_reg <= 8'h00;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      pulse_cnt_reg <= 3'h0;
      precomp_reg <= 1'b0;
      restore_pend_reg <= 1'b1;
      o_data_request <= 1'b0;
      o_command_done_irq <= 1'b0;
      o_step <= 1'b0;
      o_step_direction <= 1'b0;
      o_head_load_out <= 1'b0;
      o_write_gate <= 1'b0;
      o_write_pulse_out <= 1'b0;
      o_high_track_flag <= 1'b0;
    end else if (i_ce && !i_master_reset_n) begin
      // Held in reset while the pin is low
      state_reg <= ST_IDLE;
      restore_pend_reg <= 1'b1;
      o_write_gate <= 1'b0;
      o_write_pulse_out <= 1'b0;
      o_step <= 1'b0;
      o_command_done_irq <= 1'b0;
      o_data_request <= 1'b0;
    end else if (i_ce) begin
      // Host register writes
      if (wr_edge) begin
        case (i_register_select)
          `FDC_SEL_CMD_STAT: begin
            command_reg <= i_bus_in;
            o_command_done_irq <= 1'b0;
            status_reg <= 8'h01;
            state_reg <= ST_HEAD;
          end
          `FDC_SEL_TRACK: track_reg <= i_bus_in;
          `FDC_SEL_SECTOR: sector_reg <= i_bus_in;
          default: data_reg <= i_bus_in;
        endcase
      end else if (restore_pend_reg && mr_prev_reg) begin
        // Restore after reset release
        restore_pend_reg <= 1'b0;
        command_reg <= {`FDC_CMD_RESTORE, 4'h0};
        status_reg <= 8'h01;
        state_reg <= ST_HEAD;
      end
      // Status read clears interrupt; a set in the same cycle wins
      if (rd_edge && i_register_select == `FDC_SEL_CMD_STAT &&
          !state_reg[7]) begin
        o_command_done_irq <= 1'b0;
      end
      if (fifo_pop && !state_reg[6]) begin
        data_reg <= fifo_out_data;
      end
      // Data request: read byte waiting, or write buffer empty
      o_data_request <= (~is_type1 & ~cmd_family[1] & fifo_out_valid) |
        ((state_reg[5] | state_reg[6]) & fifo_in_ready & ~fifo_out_valid &
        (bytes_reg != 8'h00));
      status_reg[`FDC_ST_DRQ] <= o_data_request;
      // High track only meaningful in read/write
      o_high_track_flag <= (track_reg >= `FDC_HIGH_TRACK_LO) &&
        (track_reg <= `FDC_HIGH_TRACK_HI) && !is_type1;
      if (timer_reg != 6'h00 && tick) begin
        timer_reg <= timer_reg - 6'h01;
      end
      if (!wr_edge && tick) begin
        case (state_reg)
          ST_IDLE: begin
            o_write_gate <= 1'b0;
          end
          ST_HEAD: begin
            o_head_load_out <= 1'b1;
            if (is_type1) begin
              // Positioning ignores drive ready
              case (cmd_family)
                `FDC_CMD_RESTORE: target_reg <= 8'h00;
                `FDC_CMD_SEEK: target_reg <= data_reg;
                `FDC_CMD_STEP_IN: target_reg <= track_reg + 8'h01;
                default: target_reg <= track_reg - 8'h01;
              endcase
              state_reg <= ST_SETTLE;
            end else if (!i_drive_ready) begin
              status_reg[`FDC_ST_NRDY] <= 1'b1;
              state_reg <= ST_DONE;
            end else if (cmd_family[1] && !i_write_protect_n) begin
              status_reg[`FDC_ST_WPROT] <= 1'b1;
              state_reg <= ST_DONE;
            end else if (i_head_engaged_in) begin
              // Wait for engaged head before data
              bytes_reg <= SECTOR_BYTES[7:0];
              bit_cnt_reg <= 4'h0;
              state_reg <= cmd_family[1] ? ST_WGATE : ST_READ;
            end
          end
          ST_SETTLE: begin
            if (timer_reg == 6'h00) begin
              if ((cmd_family == `FDC_CMD_RESTORE && !i_track_zero_n) ||
                  (cmd_family != `FDC_CMD_RESTORE &&
                  track_reg == target_reg)) begin
                if (!i_track_zero_n) begin
                  track_reg <= 8'h00;
                end
                status_reg[`FDC_ST_TRK0] <= ~i_track_zero_n;
                state_reg <= ST_DONE;
              end else begin
                // Direction set a step ahead of the pulse
                o_step_direction <= (cmd_family != `FDC_CMD_RESTORE) &&
                  (target_reg > track_reg);
                timer_reg <= 6'h02;
                state_reg <= ST_STEP;
              end
            end
          end
          ST_STEP: begin
            if (timer_reg == 6'h01) begin
              o_step <= 1'b1;
              track_reg <= o_step_direction ? track_reg + 8'h01 :
                track_reg - 8'h01;
            end else if (timer_reg == 6'h00) begin
              o_step <= 1'b0;
              timer_reg <= 6'd `FDC_STEP_PULSE_CYC;
              state_reg <= ST_SETTLE;
            end
          end
          ST_READ: begin
            // Assemble bits from the separator
            if (i_raw_read_strobe) begin
              shift_reg <= {shift_reg[6:0], i_raw_read_bit};
              bit_cnt_reg <= bit_cnt_reg[2:0] == 3'h7 ? 4'h0 :
                bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == 4'h7) begin
                bytes_reg <= bytes_reg - 8'h01;
                if (bytes_reg == 8'h01) begin
                  state_reg <= ST_DONE;
                end
              end
            end
          end
          ST_WGATE: begin
            o_write_gate <= 1'b1;
            if (o_write_gate && fifo_out_valid) begin
              state_reg <= ST_WRITE;
            end
          end
          ST_WRITE: begin
            // Serialise, one pulse per one bit
            if (timer_reg == 6'h00) begin
              if (bit_cnt_reg == 4'h0 && bytes_reg == 8'h00) begin
                // Last cell has run out, so the gate cuts no pulse
                state_reg <= ST_DONE;
              end else if (bit_cnt_reg == 4'h0) begin
                shift_reg <= fifo_out_valid ? fifo_out_data : 8'h00;
                if (!fifo_out_valid) begin
                  status_reg[`FDC_ST_LOST] <= 1'b1;
                end
                bytes_reg <= bytes_reg - 8'h01;
                bit_cnt_reg <= 4'h8;
              end else begin
                if (shift_reg[7]) begin
                  precomp_reg <= precomp_on;
                  pulse_cnt_reg <= double_density ?
                    WP_MFM_CYC[2:0] : WP_FM_CYC[2:0];
                end
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg - 4'h1;
                timer_reg <= 6'd `FDC_BIT_CELL_CYC;
              end
            end
          end
          ST_DONE: begin
            o_write_gate <= 1'b0;
            status_reg[`FDC_ST_BUSY] <= 1'b0;
            o_command_done_irq <= 1'b1;
            state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
      // Pulse shaper, precomp holds off the pulse one cycle
      if (precomp_reg) begin
        precomp_reg <= 1'b0;
      end else if (pulse_cnt_reg != 3'h0) begin
        o_write_pulse_out <= 1'b1;
        pulse_cnt_reg <= pulse_cnt_reg - 3'h1;
      end else begin
        o_write_pulse_out <= 1'b0;
      end
    end
  end
endmodule // fdc_core

/* File: verif/fdc_drive_model.sv */
/*
 Drive model for the disc controller bench: head position, track-zero,
 index and separated read bits. Assumes the core's step pins and the
 bench clock and reset.
*/
`timescale 1ns/1ps
module fdc_drive_model #(
  parameter logic [7:0] START_TRACK = 8'h03
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Head positioning from the core
  input wire logic i_step,
  input wire logic i_step_direction,
  // Drive status and read data
  output logic o_track_zero_n,
  output logic o_index_pulse_n,
  output logic o_raw_read_bit,
  output logic o_raw_read_strobe,
  output logic [7:0] o_track
);
  logic step_q;
  logic [31:0] tick;

  // Head moves on each rising step edge; outer stop clamps at zero
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_track <= START_TRACK;
      step_q <= 1'b0;
      tick <= 32'h0;
    end else begin
      step_q <= i_step;
      tick <= tick + 32'h1;
      if (i_step && !step_q) begin
        if (i_step_direction) o_track <= o_track + 8'h01;
        else if (o_track != 8'h00) o_track <= o_track - 8'h01;
      end
    end
  end

  // Status lines; read bits keep changing so nothing settles by chance
  assign o_track_zero_n = (o_track != 8'h00);
  assign o_index_pulse_n = !(tick % 2000 < 4);
  assign o_raw_read_strobe = (tick % 40 == 0);
  assign o_raw_read_bit = tick[6];
endmodule // fdc_drive_model

/* File: verif/fdc_core_chk.sv */
/*
 Checker for the disc controller core: host bus, step and write pulses.
 Assumes it sees only the core's ports; bound below the module.
*/
`timescale 1ns/1ps
module fdc_core_chk (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Inputs watched
  input wire logic i_ce,
  input wire logic i_master_reset_n,
  input wire logic i_chip_select_n,
  input wire logic i_host_write_strobe_n,
  input wire logic i_host_read_strobe_n,
  input wire logic [1:0] i_register_select,
  input wire logic i_mini_floppy_enable_n,
  input wire logic i_size_select_n,
  input wire logic i_density_select_n,
  // Outputs watched
  input wire logic o_bus_oe,
  input wire logic o_command_done_irq,
  input wire logic o_data_request,
  input wire logic o_step,
  input wire logic o_step_direction,
  input wire logic o_write_gate,
  input wire logic o_write_pulse_out
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Decoded strobes; write pulse widths are checked only on the undivided clock
  wire rd_on = !i_chip_select_n && !i_host_read_strobe_n;
  wire wr_cmd = !i_chip_select_n && !i_host_write_strobe_n &&
    i_register_select == 2'h0 && i_ce && i_master_reset_n;
  wire full = i_mini_floppy_enable_n || i_size_select_n;

  a_read_drives_bus: assert property (rd_on && i_ce |=> o_bus_oe)
    else $error("bus not driven during read");
  a_bus_released: assert property (!rd_on && !$past(rd_on) |-> !o_bus_oe)
    else $error("bus driven outside read");
  a_step_width: assert property ($rose(o_step) |-> ##[1:8] !o_step)
    else $error("step pulse too long");
  a_dir_steady: assert property (o_step |-> $stable(o_step_direction))
    else $error("direction moved in step pulse");
  a_dir_settled: assert property (
    $rose(o_step) |-> $past(o_step_direction, 2) == o_step_direction)
    else $error("direction not settled before step");
  a_pulse_mfm: assert property (
    $rose(o_write_pulse_out) && !i_density_select_n && full |->
    o_write_pulse_out [*3] ##1 !o_write_pulse_out)
    else $error("double density pulse width wrong");
  a_pulse_fm: assert property (
    $rose(o_write_pulse_out) && i_density_select_n && full |->
    o_write_pulse_out [*5] ##1 !o_write_pulse_out)
    else $error("single density pulse width wrong");
  a_gate_first: assert property (o_write_pulse_out |-> $past(o_write_gate))
    else $error("write pulse without prior gate");
  a_mreset_quiet: assert property (!i_master_reset_n |=>
    !o_command_done_irq && !o_data_request && !o_write_gate && !o_step)
    else $error("activity during master reset");
  a_irq_cmd_clear: assert property (
    wr_cmd && $past(i_chip_select_n || i_host_write_strobe_n) |=>
    !o_command_done_irq)
    else $error("irq kept after command write");
endmodule // fdc_core_chk

bind fdc_core fdc_core_chk fdc_core_chk_i (
  .i_ref_clk, .i_rst_n, .i_ce, .i_master_reset_n, .i_chip_select_n,
  .i_host_write_strobe_n, .i_host_read_strobe_n, .i_register_select,
  .i_mini_floppy_enable_n, .i_size_select_n, .i_density_select_n,
  .o_bus_oe, .o_command_done_irq, .o_data_request, .o_step,
  .o_step_direction, .o_write_gate, .o_write_pulse_out
);

/* File: verif/tb_fdc_core.sv */
/*
 Testbench for the disc controller core: host register accesses,
 stepping, refusals, sector writes and master reset.
 Assumes the core's header is on the include path and a 10 MHz clock.
*/
`timescale 1ns/1ps
module tb_fdc_core;
  localparam int SB = 4; // Short sector keeps the run brief
  logic clk, rst_n, mr_n, cs_n, we_n, re_n, ce, mfe_n, ssel_n, den_n;
  logic pce, rdy, wp_n, head_engaged_in, wd_q, gate_seen, htf_seen, hld_seen;
  logic [1:0] sel;
  logic [7:0] din, st;
  logic [7:0] cmds [4] = '{8'h10, 8'h50, 8'h70, 8'h70};
  logic [7:0] expt [4] = '{8'h2d, 8'h2e, 8'h2d, 8'h2c};
  wire [7:0] dout, trk;
  wire oe, data_request, irq, stp, dir, head_load_out, wg, wd, htf, tz_n, ip_n, rbit, rstb;
  int n_mismatch = 0, checks = 0, n_pulse, n_bytes, k;

  fdc_core #(.SECTOR_BYTES(SB)) fdc_core_i (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_master_reset_n(mr_n),
    .i_chip_select_n(cs_n), .i_host_write_strobe_n(we_n),
    .i_host_read_strobe_n(re_n), .i_register_select(sel), .i_bus_in(din),
    .o_bus_out(dout), .o_bus_oe(oe), .o_data_request(data_request),
    .o_command_done_irq(irq), .i_precomp_enable_in(pce),
    .i_mini_floppy_enable_n(mfe_n), .i_size_select_n(ssel_n),
    .i_density_select_n(den_n), .i_drive_ready(rdy),
    .i_write_protect_n(wp_n), .i_track_zero_n(tz_n),
    .i_index_pulse_n(ip_n), .i_head_engaged_in(head_engaged_in),
    .i_raw_read_bit(rbit), .i_raw_read_strobe(rstb), .o_step(stp),
    .o_step_direction(dir), .o_head_load_out(head_load_out), .o_write_gate(wg),
    .o_write_pulse_out(wd), .o_high_track_flag(htf)
  );

  fdc_drive_model fdc_drive_model_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_step(stp), .i_step_direction(dir),
    .o_track_zero_n(tz_n), .o_index_pulse_n(ip_n), .o_raw_read_bit(rbit),
    .o_raw_read_strobe(rstb), .o_track(trk)
  );

  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Tallies of what the write tests produce on the drive side
  always @(posedge clk) begin
    if (wd && !wd_q) n_pulse++;
    wd_q = wd;
    gate_seen |= wg;
    htf_seen |= wg && htf;
    hld_seen |= wg && head_load_out;
  end

  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobes held two edges; bus shows the inverse once released
  task automatic host_wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0; we_n <= 1'b0; sel <= s; din <= d;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1; we_n <= 1'b1; din <= ~d;
    @(posedge clk);
  endtask

  task automatic host_rd(input logic [1:0] s, output logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0; re_n <= 1'b0; sel <= s;
    repeat (2) @(posedge clk);
    #1 d = dout;
    check("bus enable", {7'h0, oe}, 8'h01);
    @(posedge clk);
    cs_n <= 1'b1; re_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wait_irq(input int lim);
    k = 0;
    while (irq !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    check("irq", {7'h0, irq}, 8'h01);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected nine thousand or so cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    final_report;
  end

  initial begin
    {rst_n, cs_n, we_n, re_n, sel, din} = {4'h7, 2'h0, 8'h00};
    {mr_n, ce, mfe_n, ssel_n, den_n, pce, rdy, wp_n, head_engaged_in} = 9'h1d7;
    wd_q = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_irq(5000);
    check("restore track", trk, 8'h00);
    host_rd(2'h0, st);
    check("irq after status", {7'h0, irq}, 8'h00);
    for (int i = 1; i < 3; i++) begin
      host_wr(i[1:0], 8'h5a ^ i[7:0]);
      host_rd(i[1:0], st);
      check("register", st, 8'h5a ^ i[7:0]);
    end
    host_wr(2'h1, 8'h00);
    $display("test registers done");
    host_wr(2'h3, 8'h2d);
    for (int i = 0; i < 4; i++) begin
      host_wr(2'h0, cmds[i]);
      wait_irq(5000);
      check("head track", trk, expt[i]);
      host_rd(2'h1, st);
      check("track reg", st, expt[i]);
      host_rd(2'h0, st);
      check("busy", {7'h0, st[0]}, 8'h00);
    end
    $display("test stepping done");
    rdy <= 1'b0;
    gate_seen = 1'b0;
    host_wr(2'h0, 8'h80);
    wait_irq(500);
    host_rd(2'h0, st);
    check("not ready", {7'h0, st[7]}, 8'h01);
    host_wr(2'h0, 8'h50);
    wait_irq(500);
    check("step unready", trk, 8'h2d);
    host_wr(2'h0, 8'h70);
    wait_irq(500);
    host_rd(2'h0, st);
    rdy <= 1'b1;
    wp_n <= 1'b0;
    host_wr(2'h0, 8'ha0);
    wait_irq(500);
    host_rd(2'h0, st);
    check("protected", {7'h0, st[6]}, 8'h01);
    check("no gate", {7'h0, gate_seen}, 8'h00);
    wp_n <= 1'b1;
    $display("test refusals done");
    host_wr(2'h0, 8'h80);
    {n_bytes, k} = 0;
    while (n_bytes < SB && k < 5000) begin
      @(posedge clk);
      k++;
      if (data_request === 1'b1) begin
        host_rd(2'h3, st);
        n_bytes++;
      end
    end
    wait_irq(500);
    check("read bytes", n_bytes[7:0], SB[7:0]);
    check("read drq", {7'h0, data_request}, 8'h00);
    $display("test reads done");
    for (int d = 0; d < 2; d++) begin
      den_n <= d[0];
      pce <= ~d[0];
      {n_pulse, n_bytes, k} = 0;
      {gate_seen, htf_seen, hld_seen} = 3'h0;
      host_wr(2'h0, 8'ha0);
      while (irq !== 1'b1 && k < 20000) begin
        @(posedge clk);
        k++;
        if (data_request === 1'b1) begin
          host_wr(2'h3, 8'hc3);
          n_bytes++;
        end
      end
      check("write irq", {7'h0, irq}, 8'h01);
      check("bytes", n_bytes[7:0], SB[7:0]);
      check("gate", {7'h0, gate_seen}, 8'h01);
      check("pulses", {7'h0, n_pulse > 0}, 8'h01);
      check("high track", {7'h0, htf_seen}, 8'h01);
      check("head load", {7'h0, hld_seen}, 8'h01);
      host_rd(2'h0, st);
    end
    $display("test writes done");
    host_wr(2'h3, 8'h10);
    host_wr(2'h0, 8'h10);
    repeat (100) @(posedge clk);
    mr_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check("irq in reset", {7'h0, irq}, 8'h00);
    @(posedge clk);
    mr_n <= 1'b1;
    wait_irq(5000);
    check("restored", trk, 8'h00);
    $display("test master reset done");
    // Halved rate: settle alone takes 80 cycles, full rate about 45 in all
    mfe_n <= 1'b0;
    host_wr(2'h0, 8'h50);
    wait_irq(500);
    check("halved step", trk, 8'h01);
    check("halved rate", {7'h0, k > 60}, 8'h01);
    $display("test clock halving done");
    final_report;
  end
endmodule // tb_fdc_core
